// ---- core/vector_map_pkg.sv ----
// Package with the memory map, vector table and reset values of the vector and RAM block.
package vector_map_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] ram_base_addr          = 16'h0040;
  localparam logic [15:0] direct_page_limit      = 16'h0100;
  localparam logic [15:0] flash_control_addr     = 16'hFE08;
  localparam logic [15:0] break_address_high_addr = 16'hFE09;
  localparam logic [15:0] break_address_low_addr = 16'hFE0A;
  localparam logic [15:0] break_status_control_addr = 16'hFE0B;
  localparam logic [15:0] low_voltage_status_addr = 16'hFE0C;
  localparam logic [15:0] flash_block_protect_addr = 16'hFFBE;
  localparam logic [15:0] oscillator_trim_value_addr = 16'hFFC0;
  localparam logic [15:0] watchdog_control_addr  = 16'hFFFF;
  localparam logic [15:0] vector_table_base      = 16'hFFD0;
  localparam logic [15:0] reset_vector_addr      = 16'hFFFE;
  localparam logic [15:0] swi_vector_addr        = 16'hFFFC;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  flash_control_reset    = 8'h00;
  localparam logic [7:0]  flash_control_mask     = 8'h0F;
  localparam int          flash_hven_bit         = 3;
  localparam int          flash_mass_bit         = 2;
  localparam int          flash_erase_bit        = 1;
  localparam int          flash_pgm_bit          = 0;
  localparam logic [7:0]  break_reg_reset        = 8'h00;
  localparam logic [7:0]  break_status_mask      = 8'hC0;
  localparam logic [7:0]  low_voltage_mask       = 8'h80;
  localparam logic [7:0]  block_protect_default  = 8'hFF;
  // Factory trim value; arbitrary neutral value.
  localparam logic [7:0]  factory_trim_default   = 8'h80;
  localparam logic [15:0] stack_pointer_reset    = 16'h00FF;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int          source_count           = 23;
  localparam int          timer_ch0_source       = 3;
  localparam int          timer_ch1_source       = 4;
  localparam int          converter_done_source  = 15;

  typedef struct packed {
    logic        write_strobe;
    logic        read_strobe;
    logic [15:0] address;
    logic [7:0]  write_data;
  } bus_request_t;

  typedef struct packed {
    logic        fetch_valid;
    logic [15:0] fetch_address;
    logic [4:0]  source;
  } vector_select_t;

endpackage

// ---- core/vector_priority.sv ----
// Priority encoder that picks the vector of the highest-ranked pending source.
`timescale 1ns/1ps
module vector_priority #(
  parameter int sources = vector_map_pkg::source_count
) (
  input  wire logic [sources-1:0]        pending,
  input  wire logic                      reset_request,
  input  wire logic                      swi_request,
  output vector_map_pkg::vector_select_t select
);

  // Lower source numbers rank higher, but pending bits 0, 2 and 8 are never picked; sources 16 and up rank lowest.
  always_comb begin
    select = '0;
    for (int i = sources - 1; i >= 1; i--) begin
      if (pending[i] && (i != 2) && (i != 8)) begin
        select.fetch_valid   = 1'b1;
        select.source        = 5'(i);
        // Source n lives at $FFFC - 2n, giving $FFDE for 15 and $FFF6 for 3.
        select.fetch_address = 16'(vector_map_pkg::swi_vector_addr - 16'(2 * i));
      end
    end
    if (swi_request) begin
      select.fetch_valid   = 1'b1;
      select.source        = 5'h00;
      select.fetch_address = vector_map_pkg::swi_vector_addr;
    end
    if (reset_request) begin
      select.fetch_valid   = 1'b1;
      select.source        = 5'h00;
      select.fetch_address = vector_map_pkg::reset_vector_addr;
    end
  end

endmodule

// ---- core/vector_map_and_ram_rules.sv ----
// Top of the memory map: vector selection, mapped registers and static RAM.
`timescale 1ns/1ps
module vector_map_and_ram_rules #(
  parameter int          ram_bytes   = 512,
  parameter logic [7:0]  trim_value  = vector_map_pkg::factory_trim_default
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire vector_map_pkg::bus_request_t  bus,
  output logic [7:0]                         read_data,
  input  wire logic [22:0]                   irq_pending,
  input  wire logic                          swi_request,
  input  wire logic                          low_voltage_level,
  input  wire logic                          wait_mode,
  input  wire logic                          stop_mode,
  output vector_map_pkg::vector_select_t     vector_out,
  output logic [15:0]                        stack_pointer_reset_value,
  output logic [7:0]                         trim_out,
  output logic [7:0]                         flash_control_out,
  output logic [15:0]                        break_address_out,
  output logic                               break_enable
);

  localparam int ram_aw = $clog2(ram_bytes);

  // ----------------------------------------------------------------
  // Static RAM
  // ----------------------------------------------------------------
  // The array has no reset: contents are undefined at power-on and no reset
  // source clears them. Low-power modes only gate the CPU, not the array.
  logic [7:0]        ram_mem [ram_bytes];
  logic              ram_hit;
  logic [15:0]       ram_offset;
  logic [ram_aw-1:0] ram_index;

  assign ram_offset = 16'(bus.address - vector_map_pkg::ram_base_addr);
  assign ram_index  = ram_offset[ram_aw-1:0];
  assign ram_hit    = (bus.address >= vector_map_pkg::ram_base_addr) &&
                      (ram_offset < 16'(ram_bytes));

  always_ff @(posedge clock) begin
    if (bus.write_strobe && ram_hit) begin
      // Byte-wide writes let read-modify-write bit set and clear reach every bit.
      ram_mem[ram_index] <= bus.write_data;
    end
  end

  // ----------------------------------------------------------------
  // Mapped registers
  // ----------------------------------------------------------------
  logic [7:0] flash_control_reg;
  logic [7:0] break_high_reg;
  logic [7:0] break_low_reg;
  logic [7:0] break_status_reg;
  // Power-up value only: a variable written by always_ff may not be written by another process.
  logic [7:0] block_protect_reg = vector_map_pkg::block_protect_default;
  logic [7:0] trim_reg;
  logic [7:0] flash_control_next;
  logic [7:0] wr;

  assign wr = bus.write_data;

  // Program and erase are interlocked: a write setting both keeps the old selection.
  always_comb begin
    flash_control_next = wr & vector_map_pkg::flash_control_mask;
    if (wr[vector_map_pkg::flash_pgm_bit] && wr[vector_map_pkg::flash_erase_bit]) begin
      flash_control_next[vector_map_pkg::flash_pgm_bit] =
        flash_control_reg[vector_map_pkg::flash_pgm_bit];
      flash_control_next[vector_map_pkg::flash_erase_bit] =
        flash_control_reg[vector_map_pkg::flash_erase_bit];
    end
    if (!(flash_control_next[vector_map_pkg::flash_pgm_bit] ||
          flash_control_next[vector_map_pkg::flash_erase_bit]) &&
        !flash_control_reg[vector_map_pkg::flash_hven_bit]) begin
      flash_control_next[vector_map_pkg::flash_hven_bit] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flash_control_reg <= vector_map_pkg::flash_control_reset;
    end else if (bus.write_strobe && bus.address == vector_map_pkg::flash_control_addr) begin
      flash_control_reg <= flash_control_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      break_high_reg   <= vector_map_pkg::break_reg_reset;
      break_low_reg    <= vector_map_pkg::break_reg_reset;
      break_status_reg <= vector_map_pkg::break_reg_reset;
    end else if (bus.write_strobe) begin
      if (bus.address == vector_map_pkg::break_address_high_addr) begin
        break_high_reg <= wr;
      end
      if (bus.address == vector_map_pkg::break_address_low_addr) begin
        break_low_reg <= wr;
      end
      if (bus.address == vector_map_pkg::break_status_control_addr) begin
        break_status_reg <= wr & vector_map_pkg::break_status_mask;
      end
    end
  end

  // Protect register is unaffected by reset; it holds its default from configuration.
  always_ff @(posedge clock) begin
    if (bus.write_strobe && bus.address == vector_map_pkg::flash_block_protect_addr) begin
      block_protect_reg <= wr;
    end
  end

  // Trim is restored to the factory value by every reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      trim_reg <= trim_value;
    end else if (bus.write_strobe &&
                 bus.address == vector_map_pkg::oscillator_trim_value_addr) begin
      trim_reg <= wr;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      read_data <= 8'h00;
    end else if (bus.read_strobe) begin
      if (ram_hit) begin
        read_data <= ram_mem[ram_index];
      end else begin
        case (bus.address)
          vector_map_pkg::flash_control_addr:         read_data <= flash_control_reg;
          vector_map_pkg::break_address_high_addr:    read_data <= break_high_reg;
          vector_map_pkg::break_address_low_addr:     read_data <= break_low_reg;
          vector_map_pkg::break_status_control_addr:  read_data <= break_status_reg;
          vector_map_pkg::low_voltage_status_addr:
            read_data <= {low_voltage_level, 7'h00} & vector_map_pkg::low_voltage_mask;
          vector_map_pkg::flash_block_protect_addr:   read_data <= block_protect_reg;
          vector_map_pkg::oscillator_trim_value_addr: read_data <= trim_reg;
          default:                                    read_data <= 8'h00;
        endcase
      end
    end else begin
      read_data <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Vector selection and core reset values
  // ----------------------------------------------------------------
  vector_priority #(
    .sources (vector_map_pkg::source_count)
  ) u_priority (
    .pending       (irq_pending),
    .reset_request (rst),
    .swi_request   (swi_request),
    .select        (vector_out)
  );

  assign stack_pointer_reset_value = vector_map_pkg::stack_pointer_reset;
  assign trim_out          = trim_reg;
  assign flash_control_out = flash_control_reg;
  assign break_address_out = {break_high_reg, break_low_reg};
  assign break_enable      = break_status_reg[7] && !(wait_mode && stop_mode);

endmodule

// ---- verif/vector_map_and_ram_rules_assertions.sv ----
// Checker for vector choice, reset values and RAM readback at the block's ports.
`timescale 1ns/1ps
module vector_map_checker #(
  parameter logic [7:0] trim_value = 8'h80
) (
  input wire logic                           clock,
  input wire logic                           rst,
  input wire vector_map_pkg::bus_request_t   bus,
  input wire logic [7:0]                     read_data,
  input wire logic [22:0]                    irq_pending,
  input wire logic                           swi_request,
  input wire vector_map_pkg::vector_select_t vector_out,
  input wire logic [15:0]                    stack_pointer_reset_value,
  input wire logic [7:0]                     trim_out
);
  default clocking @(posedge clock); endclocking
  logic [15:0] last_addr_reg;
  logic [7:0]  last_data_reg;
  wire         ram_hit = bus.address >= 16'h0040 && bus.address < 16'h0240;
  // Only the latest RAM write is remembered; reset does not clear it since RAM survives reset.
  always_ff @(posedge clock) begin
    if (bus.write_strobe && ram_hit) begin
      last_addr_reg <= bus.address;
      last_data_reg <= bus.write_data;
    end
  end
  chk_ram_readback: assert property (disable iff (rst)
    bus.read_strobe && ram_hit && bus.address == last_addr_reg |=> read_data == last_data_reg)
    else $error("ram readback wrong");
  chk_adc_vector: assert property (disable iff (rst)
    irq_pending == 23'h008000 && !swi_request |-> vector_out.fetch_address == 16'hFFDE)
    else $error("converter vector wrong");
  chk_ch0_vector: assert property (disable iff (rst)
    irq_pending[3] && !irq_pending[1] && !swi_request |-> vector_out.fetch_address == 16'hFFF6)
    else $error("channel 0 vector wrong");
  chk_ch1_vector: assert property (disable iff (rst)
    irq_pending[4] && irq_pending[3:1] == 3'h0 && !swi_request
    |-> vector_out.fetch_address == 16'hFFF4) else $error("channel 1 vector wrong");
  chk_reset_vector: assert property (
    rst |-> vector_out.fetch_valid && vector_out.fetch_address == 16'hFFFE)
    else $error("reset vector wrong");
  chk_swi_rank: assert property (disable iff (rst)
    swi_request |-> vector_out.fetch_address == 16'hFFFC) else $error("swi rank wrong");
  chk_stack_value: assert property (
    $fell(rst) |-> stack_pointer_reset_value == 16'h00FF) else $error("stack value wrong");
  chk_trim_reset: assert property (
    rst |=> trim_out == trim_value) else $error("trim not restored");
endmodule

bind vector_map_and_ram_rules vector_map_checker #(.trim_value(trim_value)) check_inst (
  .clock, .rst, .bus, .read_data, .irq_pending, .swi_request, .vector_out,
  .stack_pointer_reset_value, .trim_out);

// ---- verif/cpu_model.sv ----
// Processor core model that issues single-cycle bus writes and reads.
`timescale 1ns/1ps
module cpu_model (
  input  wire logic                    clock,
  output vector_map_pkg::bus_request_t bus,
  input  wire logic [7:0]              read_data
);
  initial bus = '0;
  task automatic write_byte(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic read_byte(input logic [15:0] a, output logic [7:0] v);
    @(posedge clock);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus <= '0;
    #1 v = read_data;
  endtask
endmodule

// ---- verif/test_vector_map_and_ram_rules.sv ----
// Self-checking bench for vector choice, mapped registers and RAM.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", n, e, a); end end
module test_vector_map_and_ram_rules;
  logic                           clock = 0;
  logic                           rst = 1;
  logic                           swi_request = 0;
  logic                           low_voltage_level = 0;
  logic                           wait_mode = 0;
  logic                           stop_mode = 0;
  logic [22:0]                    irq_pending = '0;
  logic [7:0]                     read_data, trim_out, flash_control_out, d;
  logic [15:0]                    break_address_out, stack_pointer_reset_value, r;
  logic                           break_enable;
  vector_map_pkg::bus_request_t   bus;
  vector_map_pkg::vector_select_t vector_out;
  int                             num_errors = 0;
  int                             checks = 0;
  int                             ram[int];
  int                             a;
  initial forever #5 clock = ~clock;
  cpu_model cpu (.clock(clock), .bus(bus), .read_data(read_data));
  vector_map_and_ram_rules dut (.clock(clock), .rst(rst), .bus(bus), .read_data(read_data),
    .irq_pending(irq_pending), .swi_request(swi_request), .wait_mode(wait_mode),
    .low_voltage_level(low_voltage_level), .stop_mode(stop_mode), .vector_out(vector_out),
    .stack_pointer_reset_value(stack_pointer_reset_value), .trim_out(trim_out),
    .flash_control_out(flash_control_out), .break_address_out(break_address_out),
    .break_enable(break_enable));
  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    cpu.read_byte(ad, d);
    `CHK("read", e, d)
  endtask
  task automatic vec(input logic [22:0] p, input logic s, input logic [15:0] e);
    @(posedge clock);
    irq_pending <= p;
    swi_request <= s;
    #1 `CHK("vector", e, vector_out.fetch_address)
    `CHK("vector valid", 1'b1, vector_out.fetch_valid)
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst <= 1;
    #1 `CHK("reset vector", 16'hFFFE, vector_out.fetch_address)
    repeat (4) @(posedge clock);
    rst <= 0;
    #1 `CHK("trim", vector_map_pkg::factory_trim_default, trim_out)
    `CHK("stack", 16'h00FF, stack_pointer_reset_value)
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h153bfc77));
    do_reset();
    for (a = 16'hFE07; a <= 16'hFE0C; a++) rd(a[15:0], 8'h00);
    rd(16'hFFFF, 8'h00);
    low_voltage_level <= 1'b1;
    rd(16'hFE0C, 8'h80);
    r = 16'($urandom);
    cpu.write_byte(16'hFE09, r[15:8]);
    cpu.write_byte(16'hFE0A, r[7:0]);
    // The write lands at the edge on which the task returns, so look a step later.
    #1 `CHK("break address", r, break_address_out)
    rd(16'hFE09, r[15:8]);
    cpu.write_byte(16'hFE0B, 8'hFF);
    rd(16'hFE0B, 8'hC0);
    `CHK("break enable", 1'b1, break_enable)
    // Program and erase may never stand together, and high voltage can only be switched on together with one of them.
    cpu.write_byte(16'hFE08, 8'h03);
    rd(16'hFE08, 8'h00);
    cpu.write_byte(16'hFE08, 8'h09);
    rd(16'hFE08, 8'h09);
    `CHK("flash control out", 8'h09, flash_control_out)
    cpu.write_byte(16'hFE08, 8'h00);
    cpu.write_byte(16'hFE08, 8'h08);
    rd(16'hFE08, 8'h00);
    cpu.write_byte(16'hFFC0, 8'h55);
    rd(16'hFFC0, 8'h55);
    for (int i = 0; i < 40; i++) begin
      a = (i == 0) ? 32'h40 : (i == 1) ? 32'hFF : (i == 2) ? 32'h23F : 32'h40 + $urandom_range(511);
      ram[a] = $urandom_range(255);
      cpu.write_byte(a[15:0], 8'(ram[a]));
    end
    for (int i = 0; i < 16; i++) begin
      ram[32'hFF] = ram[32'hFF] ^ (1 << (i % 8));
      cpu.write_byte(16'h00FF, 8'(ram[32'hFF]));
      rd(16'h00FF, 8'(ram[32'hFF]));
    end
    wait_mode <= 1'b1;
    stop_mode <= 1'b1;
    do_reset();
    foreach (ram[k]) rd(k[15:0], 8'(ram[k]));
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
    for (int n = 1; n < 23; n++)
      if (n != 2 && n != 8) vec(23'h000001 << n, 1'b0, 16'hFFFC - 16'(2 * n));
    vec(23'h008000, 1'b0, 16'hFFDE);
    vec(23'h000018, 1'b0, 16'hFFF6);
    vec(23'h000014, 1'b0, 16'hFFF4);
    vec(23'h408000, 1'b0, 16'hFFDE);
    vec(23'h7FFFFF, 1'b1, 16'hFFFC);
    conclude();
  end
endmodule
